// ---- design/ppr_top.sv ----
// peripheral pin remap matrix with write lock and shadow monitor
`timescale 1ns/1ps
`default_nettype none
module ppr_top import ppr_pkg::*; (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [AW-1:0] i_addr,
    input wire logic [DW-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DW-1:0] o_rdata,
    input wire logic [7:0] i_osc_config_word,
    input wire logic [NUM_PINS-1:0] i_pin_in,
    output logic [NUM_INS-1:0] o_periph_in,
    input wire logic i_serial_tx_out,
    input wire logic i_serial_rts_out,
    input wire logic i_spi_data_out,
    input wire logic i_spi_clock_out,
    input wire logic i_spi_select_out,
    input wire logic i_compare_one_out,
    input wire logic i_compare_two_out,
    output logic [NUM_PINS-1:0] o_pin_out,
    output logic [NUM_PINS-1:0] o_pin_remap_active,
    output logic o_route_write_lock,
    output logic o_config_mismatch_reset
);
    logic [SW-1:0] input_route_regs [NUM_INS];
    logic [SW-1:0] input_shadow [NUM_INS];
    logic [SW-1:0] output_route_regs [NUM_PINS];
    logic [SW-1:0] output_shadow [NUM_PINS];
    logic route_write_lock;
    logic lock_ever_set;
    ppr_seq_t seq;
    ppr_seq_t next_seq;
    logic [DW-1:0] next_rdata;
    logic [NUM_INS-1:0] in_diff;
    logic [NUM_PINS-1:0] out_diff;

    wire single_session_lock_fuse = i_osc_config_word[FUSE_BIT];
    wire route_we = i_wr && !route_write_lock;
    wire osc_wr = i_wr && (i_addr == OSC_CTRL_ADDR);
    wire wr_lock_val = i_wdata[LOCK_BIT];
    // a once-set lock may not drop while the fuse asks for one session
    wire clear_refused = single_session_lock_fuse & lock_ever_set;
    wire lock_update = (seq == PPR_KEY2) && osc_wr;
    wire any_access = i_wr || i_rd;

    // output code decode, shared by all pins
    function automatic logic route_value(input logic [SW-1:0] code,
                                         input logic [6:0] src);
        logic v;
        v = 1'b0;
        case (code)
            OUT_TX: v = src[0];
            OUT_RTS: v = src[1];
            OUT_SDO: v = src[2];
            OUT_SCK: v = src[3];
            OUT_SS: v = src[4];
            OUT_OC1: v = src[5];
            OUT_OC2: v = src[6];
            default: v = 1'b0;
        endcase
        return v;
    endfunction

    function automatic logic code_known(input logic [SW-1:0] code);
        logic k;
        k = 1'b0;
        case (code)
            OUT_TX, OUT_RTS, OUT_SDO, OUT_SCK, OUT_SS, OUT_OC1, OUT_OC2:
                k = 1'b1;
            default: k = 1'b0;
        endcase
        return k;
    endfunction

    wire [6:0] periph_src = {i_compare_two_out, i_compare_one_out,
                             i_spi_select_out, i_spi_clock_out,
                             i_spi_data_out, i_serial_rts_out,
                             i_serial_tx_out};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_INS; gi++) begin : g_in
            wire sel_wr = route_we && (i_addr == IN_BASE + AW'(gi));
            wire [SW-1:0] sel = input_route_regs[gi];
            // out-of-range codes, ground code among them, read as low
            wire pin_ok = (sel < SW'(NUM_PINS));
            wire pin_val = pin_ok ? i_pin_in[sel] : 1'b0;
            always_ff @(posedge i_clk) begin
                if (!i_resetn) begin
                    input_route_regs[gi] <= IN_RESET;
                    input_shadow[gi] <= IN_RESET;
                    o_periph_in[gi] <= 1'b0;
                end else begin
                    if (sel_wr) begin
                        input_route_regs[gi] <= i_wdata[SW-1:0];
                        input_shadow[gi] <= i_wdata[SW-1:0];
                    end
                    o_periph_in[gi] <= pin_val;
                end
            end
            assign in_diff[gi] = input_route_regs[gi] != input_shadow[gi];
        end
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_out
            wire sel_wr = route_we && (i_addr == OUT_BASE + AW'(gi));
            wire [SW-1:0] sel = output_route_regs[gi];
            // unknown codes behave like null so no pin floats to garbage
            wire active = code_known(sel);
            always_ff @(posedge i_clk) begin
                if (!i_resetn) begin
                    output_route_regs[gi] <= OUT_RESET;
                    output_shadow[gi] <= OUT_RESET;
                    o_pin_out[gi] <= 1'b0;
                    o_pin_remap_active[gi] <= 1'b0;
                end else begin
                    if (sel_wr) begin
                        output_route_regs[gi] <= i_wdata[SW-1:0];
                        output_shadow[gi] <= i_wdata[SW-1:0];
                    end
                    o_pin_out[gi] <= route_value(sel, periph_src);
                    o_pin_remap_active[gi] <= active;
                end
            end
            assign out_diff[gi] = output_route_regs[gi] != output_shadow[gi];
        end
    endgenerate

    // key sequence; idle cycles between strobes do not abort it
    always_comb begin
        next_seq = seq;
        case (seq)
            PPR_IDLE: begin
                if (osc_wr && i_wdata[7:0] == KEY_ONE) begin
                    next_seq = PPR_KEY1;
                end
            end
            PPR_KEY1: begin
                if (osc_wr && i_wdata[7:0] == KEY_TWO) begin
                    next_seq = PPR_KEY2;
                end else if (any_access) begin
                    next_seq = PPR_IDLE;
                end
            end
            PPR_KEY2: begin
                if (any_access) begin
                    next_seq = PPR_IDLE;
                end
            end
            default: next_seq = PPR_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            seq <= PPR_IDLE;
            route_write_lock <= LOCK_RESET;
            lock_ever_set <= 1'b0;
        end else begin
            seq <= next_seq;
            if (lock_update && (wr_lock_val || !clear_refused)) begin
                route_write_lock <= wr_lock_val;
            end
            if (lock_update && wr_lock_val) begin
                lock_ever_set <= 1'b1;
            end
        end
    end

    always_comb begin
        next_rdata = '0;
        for (int k = 0; k < NUM_INS; k++) begin
            if (i_addr == IN_BASE + AW'(k)) begin
                next_rdata = DW'(input_route_regs[k]);
            end
        end
        for (int k = 0; k < NUM_PINS; k++) begin
            if (i_addr == OUT_BASE + AW'(k)) begin
                next_rdata = DW'(output_route_regs[k]);
            end
        end
        if (i_addr == OSC_CTRL_ADDR) begin
            next_rdata[LOCK_BIT] = route_write_lock;
        end
        if (i_addr == STATUS_ADDR) begin
            next_rdata = {12'h000, lock_ever_set, o_config_mismatch_reset,
                          seq};
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_rdata <= '0;
            o_config_mismatch_reset <= 1'b0;
        end else begin
            o_rdata <= i_rd ? next_rdata : '0;
            o_config_mismatch_reset <= |in_diff || |out_diff;
        end
    end

    assign o_route_write_lock = route_write_lock;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_key1;
        osc_wr && i_wdata[7:0] == KEY_ONE && seq == PPR_IDLE;
    endsequence
    sequence s_key2;
        osc_wr && i_wdata[7:0] == KEY_TWO;
    endsequence
    sequence s_unlock_then_clear;
        s_key1 ##1 s_key2 ##1 (osc_wr && !wr_lock_val && !clear_refused);
    endsequence

    property p_lock_blocks;
        route_write_lock && i_wr && i_addr == IN_BASE
            |=> input_route_regs[0] == $past(input_route_regs[0]);
    endproperty
    a_lock_blocks: assert property (p_lock_blocks)
        else $error("routing write changed a locked register");

    property p_in_write;
        !route_write_lock && i_wr && i_addr == IN_BASE
            |=> input_route_regs[0] == $past(i_wdata[SW-1:0]);
    endproperty
    a_in_write: assert property (p_in_write)
        else $error("input selector did not take written value");

    property p_in_route;
        input_route_regs[0] < SW'(NUM_PINS) ##1 1'b1
            |-> o_periph_in[0] == $past(i_pin_in[input_route_regs[0]]);
    endproperty
    a_in_route: assert property (p_in_route)
        else $error("peripheral input not following selected pin");

    property p_in_ground;
        input_route_regs[1] == IN_GROUND |=> !o_periph_in[1];
    endproperty
    a_in_ground: assert property (p_in_ground)
        else $error("ground code did not tie input low");

    property p_out_null;
        output_route_regs[0] == OUT_NULL
            |=> !o_pin_remap_active[0] && !o_pin_out[0];
    endproperty
    a_out_null: assert property (p_out_null)
        else $error("null code still drives the pin");

    property p_out_tx;
        output_route_regs[3] == OUT_TX
            |=> o_pin_remap_active[3]
                && o_pin_out[3] == $past(i_serial_tx_out);
    endproperty
    a_out_tx: assert property (p_out_tx)
        else $error("transmit code does not route serial transmit");

    property p_out_oc2;
        output_route_regs[3] == OUT_OC2
            |=> o_pin_out[3] == $past(i_compare_two_out);
    endproperty
    a_out_oc2: assert property (p_out_oc2)
        else $error("compare two code misrouted");

    property p_unlock;
        s_unlock_then_clear |=> !route_write_lock;
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("valid key sequence did not clear the lock");

    property p_lock_holds;
        !lock_update |=> route_write_lock == $past(route_write_lock);
    endproperty
    a_lock_holds: assert property (p_lock_holds)
        else $error("lock changed without the key sequence");

    property p_abort;
        seq == PPR_KEY1 && i_rd |=> seq == PPR_IDLE ##1 !lock_update;
    endproperty
    a_abort: assert property (p_abort)
        else $error("intervening access did not abort the sequence");

    property p_one_session;
        single_session_lock_fuse && lock_ever_set && route_write_lock
            |=> route_write_lock;
    endproperty
    a_one_session: assert property (p_one_session)
        else $error("lock cleared although fuse allows one session");

    property p_mismatch;
        (|in_diff || |out_diff) |=> o_config_mismatch_reset;
    endproperty
    a_mismatch: assert property (p_mismatch)
        else $error("shadow difference did not raise mismatch reset");

    property p_out_sck;
        output_route_regs[3] == OUT_SCK
            |=> o_pin_remap_active[3]
                && o_pin_out[3] == $past(i_spi_clock_out);
    endproperty
    a_out_sck: assert property (p_out_sck)
        else $error("spi clock code misrouted");

    property p_out_unknown;
        !code_known(output_route_regs[3])
            |=> !o_pin_remap_active[3] && !o_pin_out[3];
    endproperty
    a_out_unknown: assert property (p_out_unknown)
        else $error("unused output code took the pin");

    property p_out_write;
        !route_write_lock && i_wr && i_addr == OUT_BASE + 8'h03
            |=> output_route_regs[3] == $past(i_wdata[SW-1:0]);
    endproperty
    a_out_write: assert property (p_out_write)
        else $error("output selector did not take written value");

    property p_out_locked;
        route_write_lock && i_wr && i_addr == OUT_BASE + 8'h03
            |=> output_route_regs[3] == $past(output_route_regs[3]);
    endproperty
    a_out_locked: assert property (p_out_locked)
        else $error("locked output selector changed");

    property p_in_loop;
        input_route_regs[6] == 5'h03
            |=> o_periph_in[6] == $past(i_pin_in[3]);
    endproperty
    a_in_loop: assert property (p_in_loop)
        else $error("input routing disturbed by output routing");

    property p_key_advance;
        s_key1 ##1 s_key2 |=> seq == PPR_KEY2;
    endproperty
    a_key_advance: assert property (p_key_advance)
        else $error("two keys did not arm the lock update");

    property p_lock_set;
        s_key1 ##1 s_key2 ##1 (osc_wr && wr_lock_val)
            |=> route_write_lock;
    endproperty
    a_lock_set: assert property (p_lock_set)
        else $error("valid key sequence did not set the lock");

    property p_multi_session;
        !single_session_lock_fuse && lock_update && !wr_lock_val
            |=> !route_write_lock;
    endproperty
    a_multi_session: assert property (p_multi_session)
        else $error("lock not cleared with fuse programmed to zero");

    property p_rd_lock;
        i_rd && i_addr == OSC_CTRL_ADDR
            |=> o_rdata[LOCK_BIT] == $past(route_write_lock);
    endproperty
    a_rd_lock: assert property (p_rd_lock)
        else $error("lock bit read back wrong");
endmodule
`default_nettype wire

// ---- design/ppr_pkg.sv ----
// constants and types for the peripheral pin remap block
// Operation
// - each peripheral input has a 5-bit selector; value n picks remap pin n.
// - selector values beyond this variant's pin count reach no pin.
// - input and output routing are chosen independently of each other.
// - each remap pin has a 5-bit selector choosing the driving peripheral.
// - output code 00000 drives nothing; pin stays with its port logic.
// - code 00011 routes serial transmit, 00100 serial request-to-send.
// - codes 00111, 01000, 01001 route spi data, clock, select out.
// - codes 10010 and 10011 route compare unit one and two outputs.
// - while locked, routing writes complete but leave contents unchanged.
// - lock is bit 6 of oscillator control; one blocks, zero permits.
// - lock changes only after keys 0x46 then 0x57 to the low byte.
// - lock holds its state until explicitly changed by the sequence.
// - shadow copies are compared continuously; a difference forces reset.
// - with fuse bit 5 set, a set lock can be cleared only by reset.
// - fuse unprogrammed is one, one session; zero allows unlimited sessions.
// - input selectors reset to 11111, which ties the input to ground.
package ppr_pkg;
    localparam int NUM_PINS = 26;
    localparam int NUM_INS = 14;
    localparam int AW = 8;
    localparam int DW = 16;
    localparam int SW = 5;
    localparam logic [AW-1:0] IN_BASE = 8'h00;
    localparam logic [AW-1:0] OUT_BASE = 8'h20;
    localparam logic [AW-1:0] OSC_CTRL_ADDR = 8'h40;
    localparam logic [AW-1:0] STATUS_ADDR = 8'h41;
    localparam int LOCK_BIT = 6;
    localparam int FUSE_BIT = 5;
    localparam logic [7:0] KEY_ONE = 8'h46;
    localparam logic [7:0] KEY_TWO = 8'h57;
    localparam logic [SW-1:0] IN_RESET = 5'h1F;
    localparam logic [SW-1:0] IN_GROUND = 5'h1F;
    localparam logic [SW-1:0] OUT_RESET = 5'h00;
    localparam logic [SW-1:0] OUT_NULL = 5'h00;
    localparam logic [SW-1:0] OUT_TX = 5'h03;
    localparam logic [SW-1:0] OUT_RTS = 5'h04;
    localparam logic [SW-1:0] OUT_SDO = 5'h07;
    localparam logic [SW-1:0] OUT_SCK = 5'h08;
    localparam logic [SW-1:0] OUT_SS = 5'h09;
    localparam logic [SW-1:0] OUT_OC1 = 5'h12;
    localparam logic [SW-1:0] OUT_OC2 = 5'h13;
    localparam logic LOCK_RESET = 1'b0;
    typedef enum logic [1:0] {
        PPR_IDLE = 2'b00,
        PPR_KEY1 = 2'b01,
        PPR_KEY2 = 2'b10
    } ppr_seq_t;
endpackage

// ---- test/ppr_partner.sv ----
// far-side model: peripheral outputs and remappable pin pads
`timescale 1ns/1ps
`default_nettype none
module ppr_partner import ppr_pkg::*; (
    input wire logic [6:0] i_drive,
    input wire logic [NUM_PINS-1:0] i_port_level,
    input wire logic [NUM_PINS-1:0] i_pin_out,
    input wire logic [NUM_PINS-1:0] i_pin_remap_active,
    output logic [NUM_PINS-1:0] o_pin_level,
    output logic o_serial_tx_out,
    output logic o_serial_rts_out,
    output logic o_spi_data_out,
    output logic o_spi_clock_out,
    output logic o_spi_select_out,
    output logic o_compare_one_out,
    output logic o_compare_two_out
);
    // every pad is taken as set to input, so a routed input sees the pad
    // remapped pads show the peripheral, all others their port level
    assign o_pin_level = (i_pin_remap_active & i_pin_out)
        | (~i_pin_remap_active & i_port_level);
    assign {o_compare_two_out, o_compare_one_out, o_spi_select_out,
        o_spi_clock_out, o_spi_data_out, o_serial_rts_out,
        o_serial_tx_out} = i_drive;
endmodule
`default_nettype wire

// ---- test/ppr_top_tb.sv ----
// self-checking bench for the pin remap block
`timescale 1ns/1ps
`default_nettype none
module ppr_top_tb import ppr_pkg::*;;
    logic i_clk = 0, i_resetn = 0, i_wr = 0, i_rd = 0;
    logic [AW-1:0] i_addr = '0;
    logic [DW-1:0] i_wdata = '0;
    logic [DW-1:0] o_rdata, rd;
    logic [7:0] fuse = '0;
    logic [6:0] drive = '0;
    logic [NUM_PINS-1:0] lvl = '0;
    logic [NUM_PINS-1:0] pout, act;
    logic [NUM_INS-1:0] periph;
    logic lock, mm;
    wire [2:0] pin3_view = {act[3], pout[3], periph[6]};
    wire [NUM_PINS-1:0] pins;
    wire [6:0] po;
    int mismatches = 0;
    int cmp_count = 0;
    always #25 i_clk = ~i_clk;
    ppr_top uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_osc_config_word(fuse), .i_pin_in(pins), .o_periph_in(periph),
        .i_serial_tx_out(po[0]), .i_serial_rts_out(po[1]),
        .i_spi_data_out(po[2]), .i_spi_clock_out(po[3]),
        .i_spi_select_out(po[4]), .i_compare_one_out(po[5]),
        .i_compare_two_out(po[6]), .o_pin_out(pout),
        .o_pin_remap_active(act), .o_route_write_lock(lock),
        .o_config_mismatch_reset(mm));
    ppr_partner far (.i_drive(drive), .i_port_level(lvl), .i_pin_out(pout),
        .i_pin_remap_active(act), .o_pin_level(pins),
        .o_serial_tx_out(po[0]), .o_serial_rts_out(po[1]),
        .o_spi_data_out(po[2]), .o_spi_clock_out(po[3]),
        .o_spi_select_out(po[4]), .o_compare_one_out(po[5]),
        .o_compare_two_out(po[6]));
    task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rdr(input logic [AW-1:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 rd = o_rdata;
    endtask
    // routing passes two registers, pin out then peripheral in; the pad loop adds none, the third edge is margin
    task automatic settle;
        repeat (3) @(posedge i_clk);
        #1;
    endtask
    // keys and update back to back, no idle cycle between them
    task automatic keys(input logic [DW-1:0] upd);
        @(posedge i_clk);
        i_addr <= OSC_CTRL_ADDR;
        i_wdata <= {8'h00, KEY_ONE};
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wdata <= {8'h00, KEY_TWO};
        @(posedge i_clk);
        i_wdata <= upd;
        @(posedge i_clk);
        i_wr <= 1'b0;
        settle;
    endtask
    task automatic t_reset;
        @(posedge i_clk) lvl <= '1;
        settle;
        chk(16'(periph), '0);
        rdr(IN_BASE + 8'h0D);
        chk(rd, 16'h001F);
        rdr(OUT_BASE + 8'h19);
        chk(rd, 16'h0000);
        chk(act[15:0], '0);
        rdr(OSC_CTRL_ADDR);
        chk(rd & 16'h0040, 16'h0000);
    endtask
    task automatic t_input;
        logic [4:0] sel [5] = '{5'h05, 5'h08, 5'h19, 5'h1A, 5'h00};
        wr(IN_BASE, 16'hFFE5);
        rdr(IN_BASE);
        chk(rd, 16'h0005);
        for (int i = 1; i < 5; i++) begin
            wr(IN_BASE + 8'(i), 16'(sel[i]));
        end
        @(posedge i_clk) lvl <= 26'h2AAAAAA;
        settle;
        chk(16'(periph[4:0]), 16'h0005);
        @(posedge i_clk) lvl <= ~26'h2AAAAAA;
        settle;
        chk(16'(periph[4:0]), 16'h0012);
    endtask
    task automatic t_output;
        logic [4:0] code [7] = '{5'h03, 5'h04, 5'h07, 5'h08, 5'h09,
            5'h12, 5'h13};
        // input 6 listens on pin 3 while pin 3 is driven as an output
        wr(IN_BASE + 8'h06, 16'h0003);
        for (int k = 0; k < 7; k++) begin
            wr(OUT_BASE + 8'h03, 16'(code[k]));
            @(posedge i_clk) drive <= 7'(1 << k);
            settle;
            chk(16'(pin3_view), 16'h0007);
            @(posedge i_clk) drive <= ~7'(1 << k);
            settle;
            chk(16'(pin3_view), 16'h0004);
        end
        @(posedge i_clk) lvl <= '1;
        wr(OUT_BASE + 8'h03, 16'h0000);
        @(posedge i_clk) drive <= '1;
        settle;
        chk(16'({act[3], pout[3], periph[6]}), 16'h0001);
        wr(OUT_BASE + 8'h03, 16'h0005);
        settle;
        chk(16'({act[3], pout[3], periph[6]}), 16'h0001);
    endtask
    task automatic t_lock;
        keys(16'h0040);
        chk(16'(lock), 16'h0001);
        rdr(OSC_CTRL_ADDR);
        chk(rd & 16'h0040, 16'h0040);
        wr(IN_BASE, 16'h000A);
        wr(OUT_BASE + 8'h03, 16'h0003);
        settle;
        rdr(IN_BASE);
        chk(rd, 16'h0005);
        chk(16'(act[3]), 16'h0000);
        // a read between the keys must spoil the sequence
        wr(OSC_CTRL_ADDR, 16'h0046);
        rdr(STATUS_ADDR);
        wr(OSC_CTRL_ADDR, 16'h0057);
        wr(OSC_CTRL_ADDR, 16'h0000);
        settle;
        chk(16'(lock), 16'h0001);
        keys(16'h0000);
        chk(16'(lock), 16'h0000);
        wr(IN_BASE, 16'h000A);
        wr(IN_BASE + 8'h01, 16'h000B);
        rdr(IN_BASE);
        chk(rd, 16'h000A);
    endtask
    task automatic t_fuse;
        @(posedge i_clk) fuse <= 8'h20;
        keys(16'h0040);
        keys(16'h0000);
        chk(16'(lock), 16'h0001);
        @(posedge i_clk) i_resetn <= 1'b0;
        repeat (20) @(posedge i_clk);
        i_resetn <= 1'b1;
        rdr(IN_BASE);
        chk(rd, 16'h001F);
        chk(16'(lock), 16'h0000);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge i_clk);
        i_resetn <= 1'b1;
        t_reset;
        t_input;
        t_output;
        t_lock;
        t_fuse;
        chk(16'(mm), 16'h0000);
        tally_and_finish;
    end
    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (5000) @(posedge i_clk);
        mismatches++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
